// file: adc_sync_pkg.sv
// Constants, types and register map for the converter sync and clock-shift control
package adc_sync_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;
  localparam logic [3:0] US_DIV_LOAD = 4'(US_CYC - 1);
  localparam logic [7:0] SETTLE_LINKS = 8'h96;
  // Cycle time limits in microseconds
  localparam logic [15:0] CYC_MIN_US = 16'h0032;
  localparam logic [15:0] CYC_MAX_US = 16'h07D0;
  // Clock shift mapping
  localparam logic signed [7:0] SHIFT_LIM = 8'sh32;
  localparam int PPM_STEP = 200;
  localparam int SERIAL_MOD = 100;
  localparam int SERIAL_MID = 50;
  localparam int DEF_PPM_STEP = -200;
  // Converter setup fields
  localparam logic [3:0] RATE_SYNC = 4'hE;
  localparam logic [7:0] SETUP_WR_MASK = 8'h7F;
  // Register offsets
  localparam logic [7:0] OFF_SETUP = 8'h00;
  localparam logic [7:0] OFF_CYCLE = 8'h04;
  localparam logic [7:0] OFF_SHIFT = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_LINK = 8'h10;
  // Reset values
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [15:0] CYC_RST = 16'h03E8;
  localparam logic [7:0] SHIFT_RST = 8'h00;

  typedef struct packed {
    logic [4:0] rsvd;
    logic not_sync;
    logic open_ckt;
    logic invalid;
  } state_flags_s;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_s;

  typedef enum {CHK_IDLE, CHK_RUN} chk_state_e;
endpackage

// file: pulse_div.sv
// Down-counting divider giving one-cycle enable pulses
`timescale 1ns/10ps
`default_nettype none
module pulse_div #(parameter int W = 4) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] load,
  output logic pulse
);
  logic [W-1:0] cnt_ff;

  // Reload on zero and fire one pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      pulse <= 1'b0;
    end else if (en) begin
      pulse <= (cnt_ff == '0);
      cnt_ff <= (cnt_ff == '0) ? load : cnt_ff - 1'b1;
    end else begin
      pulse <= 1'b0;
    end
  end

  pulse_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    pulse |-> $past(cnt_ff) == '0 && $past(en))
    else $error("divider pulse without terminal count");
endmodule
`default_nettype wire

// file: shift_map.sv
// Maps the clock-shift setting and serial number to a ppm offset
`timescale 1ns/10ps
`default_nettype none
module shift_map import adc_sync_pkg::*; (
  input wire logic signed [7:0] shift,
  input wire logic [15:0] serial_no,
  output logic signed [15:0] ppm,
  output logic in_range
);
  // Linear steps inside the window, serial default outside
  always_comb begin
    int s;
    int r;
    s = int'(shift);
    r = int'(serial_no % 16'(SERIAL_MOD)) - SERIAL_MID;
    in_range = (shift >= -SHIFT_LIM) && (shift <= SHIFT_LIM);
    if (in_range) begin
      ppm = 16'(s * PPM_STEP);
    end else begin
      ppm = 16'(r * DEF_PPM_STEP);
    end
  end
endmodule
`default_nettype wire

// file: adc_sync_ctrl.sv
// Converter sync, lock check, clock shift and status over APB
`timescale 1ns/10ps
`default_nettype none
module adc_sync_ctrl import adc_sync_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_tick,
  input wire logic [15:0] serial_no,
  input wire logic conv_valid,
  input wire logic meas_done,
  input wire logic meas_open,
  output logic sample_pulse,
  output logic signed [15:0] shift_ppm,
  output logic [7:0] state_flags
);
  apb_req_s req;
  logic us_tick;
  logic setup_ph;
  logic wr_acc;
  logic sync_mode;
  logic cyc_wr_chg;
  logic settling;
  logic locked;
  logic open_now;
  logic map_in_range;
  logic signed [15:0] map_ppm;
  logic [31:0] rd_data;
  logic rd_err;

  logic [7:0] setup_ff;
  logic [15:0] cyc_ff;
  logic signed [7:0] shift_ff;
  state_flags_s flags_ff;
  logic [15:0] lnk_cnt_ff;
  logic [15:0] link_us_ff;
  logic sync_d_ff;
  logic [7:0] settle_ff;
  logic open_acc_ff;
  chk_state_e chk_ff;
  logic [15:0] rem_ff;
  logic [15:0] small_ff;
  logic [15:0] quot_ff;
  logic lock_ok_ff;
  logic mult_ff;
  logic [15:0] ratio_ff;
  logic [15:0] phase_ff;
  logic [15:0] idx_ff;
  logic sample_ff;
  logic signed [15:0] shift_ppm_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // Microsecond time base
  pulse_div #(.W(4)) us_div (
    .clk(pclk),
    .rst_n(presetn),
    .en(1'b1),
    .load(US_DIV_LOAD),
    .pulse(us_tick)
  );

  // Shift setting to ppm offset
  shift_map mapper (
    .shift(shift_ff),
    .serial_no(serial_no),
    .ppm(map_ppm),
    .in_range(map_in_range)
  );

  // Bus request decode
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready_ff & req.write;
  assign sync_mode = (setup_ff[3:0] == RATE_SYNC);
  assign cyc_wr_chg = wr_acc && (req.addr == OFF_CYCLE) && (req.wdata[15:0] != cyc_ff);
  assign settling = (settle_ff != SETTLE_LINKS);
  assign locked = sync_mode & lock_ok_ff;
  assign open_now = meas_done & meas_open;

  // Read data and error for the addressed register
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (req.addr == OFF_SETUP) begin
      rd_data[7:0] = setup_ff;
    end else if (req.addr == OFF_CYCLE) begin
      rd_data[15:0] = cyc_ff;
    end else if (req.addr == OFF_SHIFT) begin
      rd_data[7:0] = shift_ff;
    end else if (req.addr == OFF_FLAGS) begin
      rd_data[7:0] = flags_ff;
    end else if (req.addr == OFF_LINK) begin
      rd_data[15:0] = link_us_ff;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Zero-wait answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & rd_err;
      prdata_ff <= (setup_ph && !req.write) ? rd_data : '0;
    end
  end

  // Writable configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ff <= SETUP_RST;
      cyc_ff <= CYC_RST;
      shift_ff <= SHIFT_RST;
    end else if (wr_acc) begin
      if (req.addr == OFF_SETUP) begin
        setup_ff <= req.wdata[7:0] & SETUP_WR_MASK;
      end else if (req.addr == OFF_CYCLE) begin
        cyc_ff <= req.wdata[15:0];
      end else if (req.addr == OFF_SHIFT) begin
        shift_ff <= req.wdata[7:0];
      end
    end
  end

  // Link period measured in microseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk_cnt_ff <= '0;
      link_us_ff <= '0;
    end else if (link_tick) begin
      link_us_ff <= lnk_cnt_ff;
      lnk_cnt_ff <= us_tick ? 16'h0001 : 16'h0000; // Coinciding us tick belongs to new cycle
    end else if (us_tick && lnk_cnt_ff != 16'hFFFF) begin
      lnk_cnt_ff <= lnk_cnt_ff + 1'b1;
    end
  end

  // Ratio check by repeated subtraction, once per link cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_ff <= CHK_IDLE;
      rem_ff <= '0;
      small_ff <= '0;
      quot_ff <= '0;
      lock_ok_ff <= 1'b0;
      mult_ff <= 1'b0;
      ratio_ff <= '0;
    end else if (link_tick) begin
      chk_ff <= CHK_RUN;
      rem_ff <= (cyc_ff > lnk_cnt_ff) ? cyc_ff : lnk_cnt_ff;
      small_ff <= (cyc_ff > lnk_cnt_ff) ? lnk_cnt_ff : cyc_ff;
      quot_ff <= '0;
    end else begin
      case (chk_ff)
        CHK_IDLE: begin
          chk_ff <= CHK_IDLE;
        end
        CHK_RUN: begin
          if (small_ff == '0) begin
            lock_ok_ff <= 1'b0;
            chk_ff <= CHK_IDLE;
          end else if (rem_ff >= small_ff) begin
            rem_ff <= rem_ff - small_ff;
            quot_ff <= quot_ff + 1'b1;
          end else begin
            // Whole ratio, quarter bound and range
            lock_ok_ff <= (rem_ff == '0)
              && ({cyc_ff, 2'b00} >= {2'b00, link_us_ff})
              && (cyc_ff >= CYC_MIN_US) && (cyc_ff <= CYC_MAX_US);
            mult_ff <= (cyc_ff > link_us_ff);
            ratio_ff <= quot_ff;
            chk_ff <= CHK_IDLE;
          end
        end
        default: begin
          chk_ff <= CHK_IDLE;
        end
      endcase
    end
  end

  // Settling counter in link cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d_ff <= 1'b0;
      settle_ff <= '0;
    end else begin
      sync_d_ff <= sync_mode;
      if ((sync_mode && !sync_d_ff) || (sync_mode && cyc_wr_chg)) begin
        settle_ff <= '0;
      end else if (link_tick && settling) begin
        settle_ff <= settle_ff + 1'b1;
      end
    end
  end

  // Open circuit seen during the current link cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_acc_ff <= 1'b0;
    end else if (link_tick) begin
      open_acc_ff <= 1'b0;
    end else if (open_now) begin
      open_acc_ff <= 1'b1;
    end
  end

  // Status snapshot per link cycle, not-sync forced on cycle change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '{rsvd: '0, not_sync: 1'b1, open_ckt: 1'b0, invalid: 1'b1};
    end else begin
      if (link_tick) begin
        flags_ff.invalid <= ~conv_valid;
        flags_ff.open_ckt <= open_acc_ff | open_now;
        flags_ff.not_sync <= ~locked | settling;
      end
      if (sync_mode && cyc_wr_chg) begin
        flags_ff.not_sync <= 1'b1;
      end
    end
  end

  // Link ticks left until the next resync in multiple mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= '0;
    end else if (!locked || !mult_ff) begin
      idx_ff <= '0;
    end else if (link_tick) begin
      idx_ff <= (idx_ff == '0) ? ratio_ff - 1'b1 : idx_ff - 1'b1;
    end
  end

  // Sample instants locked to the link cycle, microsecond grid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= '0;
      sample_ff <= 1'b0;
    end else begin
      sample_ff <= 1'b0;
      if (!locked) begin
        phase_ff <= '0;
      end else if (link_tick && (!mult_ff || idx_ff == '0)) begin
        phase_ff <= '0;
        sample_ff <= (phase_ff != '0);
      end else if (us_tick) begin
        if (phase_ff + 1'b1 >= cyc_ff) begin
          phase_ff <= '0;
          sample_ff <= 1'b1;
        end else begin
          phase_ff <= phase_ff + 1'b1;
        end
      end
    end
  end

  // Frequency offset to the converter clock generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ppm_ff <= '0;
    end else begin
      shift_ppm_ff <= sync_mode ? 16'sh0000 : map_ppm;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sample_pulse = sample_ff;
  assign shift_ppm = shift_ppm_ff;
  assign state_flags = flags_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  snap_only_tick_a: assert property (
    $changed(flags_ff[1:0]) |-> $past(link_tick))
    else $error("status bits changed outside a link tick");

  settle_not_sync_a: assert property (
    (link_tick && settling) |=> flags_ff.not_sync)
    else $error("not-sync clear while settling");

  cyc_change_restart_a: assert property (
    (sync_mode && cyc_wr_chg) |=> flags_ff.not_sync && settle_ff == '0)
    else $error("cycle change did not restart settling");

  settle_length_a: assert property (
    (link_tick && settle_ff == SETTLE_LINKS - 8'h01 && sync_mode && !cyc_wr_chg
      && sync_d_ff) |=> !settling)
    else $error("settling did not end after the set count");

  sync_no_shift_a: assert property (
    sync_mode |=> shift_ppm_ff == 16'sh0000)
    else $error("shift applied in synchronous mode");

  shift_linear_a: assert property (
    (!sync_mode && map_in_range) |=> shift_ppm_ff == 16'($past(int'(shift_ff)) * PPM_STEP))
    else $error("in-range shift not linear");

  shift_default_a: assert property (
    (!sync_mode && !map_in_range) |=> shift_ppm_ff
      == 16'((int'($past(serial_no) % 16'(SERIAL_MOD)) - SERIAL_MID) * DEF_PPM_STEP))
    else $error("out-of-range shift not serial default");

  shift_low_byte_a: assert property (
    (wr_acc && req.addr == OFF_SHIFT) |=> shift_ff == $past(pwdata[7:0]))
    else $error("shift write not low byte");

  invalid_bit_a: assert property (
    link_tick |=> flags_ff.invalid == !$past(conv_valid))
    else $error("invalid bit not from converter");

  open_bit_a: assert property (
    link_tick |=> flags_ff.open_ckt == $past(open_acc_ff | open_now))
    else $error("open circuit bit wrong");

  unlocked_flag_a: assert property (
    (link_tick && !locked) |=> flags_ff.not_sync)
    else $error("not-sync clear while unlocked");

  resync_sample_a: assert property (
    (locked && link_tick && !mult_ff && phase_ff > 16'h0001) |=> sample_ff ##1 phase_ff <= 16'h0001)
    else $error("no sample at link resync");

  async_quiet_a: assert property (
    !sync_mode |=> !sample_ff)
    else $error("sample pulse outside synchronous mode");

  lock_cov_c: cover property (sync_mode && !settling && link_tick ##1 !flags_ff.not_sync);
  open_cov_c: cover property (flags_ff.open_ckt ##[1:1000] !flags_ff.open_ckt);
  default_cov_c: cover property (!sync_mode && !map_in_range);
  multiple_cov_c: cover property (locked && mult_ff && link_tick && idx_ff == '0);
endmodule
`default_nettype wire

// file: link_model.sv
// Backplane link controller model giving the periodic link cycle tick
`timescale 1ns/10ps
`default_nettype none
module link_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [15:0] period,
  output logic link_tick
);
  logic [15:0] cnt_ff;

  // One tick per link cycle, none while stopped; the period follows the period input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0;
      link_tick <= 1'b0;
    end else begin
      link_tick <= run && (cnt_ff == period - 16'h1);
      cnt_ff <= (!run || cnt_ff == period - 16'h1) ? 16'h0 : cnt_ff + 16'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the converter sync and clock-shift control
`timescale 1ns/10ps
`default_nettype none
module tb_top import adc_sync_pkg::*;;
  localparam int LIMIT = 60000;
  logic pclk, presetn, psel, penable, pwrite, conv_valid, meas_done, meas_open, run;
  logic pready, pslverr, link_tick, sample_pulse, err;
  logic [7:0] paddr, state_flags;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] shift_ppm;
  logic [15:0] serial_no, period;
  int num_errors, comparisons, cycles, pulses, g;
  // Shift writes and their offsets; serial 1234 gives the default +3200 ppm
  logic [31:0] wv [9] = '{32'h0, 32'h1, 32'hFFFFFFFF, 32'h32, 32'hFFFFFFCE, 32'h33, 32'h80,
    32'h7F, 32'h100};
  int ppm [9] = '{0, 200, -200, 10000, -10000, 3200, 3200, 3200, 0};

  adc_sync_ctrl adc_sync_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .link_tick, .serial_no, .conv_valid, .meas_done, .meas_open,
    .sample_pulse, .shift_ppm, .state_flags
  );
  link_model link_model_inst (.pclk, .presetn, .run, .period, .link_tick);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Sample pulse counter and hang guard
  always @(posedge pclk) begin
    cycles++;
    if (sample_pulse === 1'b1) pulses++;
    if (cycles == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk(n, 32'h0, {31'h0, err});
  endtask

  // Wait for link ticks, then until the flags have refreshed
  task automatic tk(input int n);
    repeat (n) @(posedge link_tick);
    repeat (2) @(posedge pclk);
  endtask

  task automatic flg(input logic [7:0] e);
    chk("state_flags", {24'h0, e}, {24'h0, state_flags});
  endtask

  // Clocks between two sample pulses; a hang ends at the bench limit
  task automatic sgap(output int n);
    n = 0;
    while (sample_pulse !== 1'b1) begin
      @(posedge pclk);
    end
    do begin
      @(posedge pclk);
      n++;
    end while (sample_pulse !== 1'b1);
  endtask

  task automatic complete_run;
    $display("Errors %0d in %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    conv_valid = 1'b0;
    meas_done = 1'b0;
    meas_open = 1'b0;
    run = 1'b0;
    period = 16'h0064;
    serial_no = 16'h04D2;
    repeat (4) @(posedge pclk);
    flg(8'h05);
    presetn <= 1'b1;
    rdc(OFF_SETUP, 32'h0, "setup");
    rdc(OFF_CYCLE, 32'h3E8, "cycle");
    rdc(OFF_SHIFT, 32'h0, "shift");
    rdc(OFF_FLAGS, 32'h05, "flags");
    apb(1'b0, 8'h14, 32'h0);
    chk("bad_addr_err", 32'h1, {31'h0, err});
    chk("bad_addr_data", 32'h0, rd);
    // Asynchronous mode: status bits per link cycle
    run <= 1'b1;
    conv_valid <= 1'b1;
    tk(2);
    flg(8'h04);
    meas_open <= 1'b1;
    @(posedge pclk);
    meas_open <= 1'b0;
    tk(1);
    flg(8'h04);
    meas_done <= 1'b1;
    meas_open <= 1'b1;
    @(posedge pclk);
    meas_done <= 1'b0;
    meas_open <= 1'b0;
    tk(1);
    flg(8'h06);
    tk(1);
    flg(8'h04);
    conv_valid <= 1'b0;
    tk(1);
    flg(8'h05);
    conv_valid <= 1'b1;
    rdc(OFF_LINK, 32'hA, "link_us");
    apb(1'b1, OFF_FLAGS, 32'hFF);
    tk(1);
    rdc(OFF_FLAGS, 32'h04, "flags_ro");
    // Clock shift table, async mode
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, OFF_SHIFT, wv[i]);
      rdc(OFF_SHIFT, wv[i] & 32'hFF, "shift_rd");
      chk("shift_ppm", 32'(ppm[i]), 32'(shift_ppm));
    end
    pulses = 0;
    repeat (600) @(posedge pclk);
    chk("async_pulses", 32'h0, 32'(pulses));
    // Synchronous mode, 50 us converter cycle on a 10 us link cycle
    apb(1'b1, OFF_SHIFT, 32'h5);
    apb(1'b1, OFF_CYCLE, 32'h32);
    apb(1'b1, OFF_SETUP, 32'hFE);
    rdc(OFF_SETUP, 32'h7E, "setup_rsvd");
    chk("sync_ppm", 32'h0, 32'(shift_ppm));
    tk(140);
    flg(8'h04);
    tk(12);
    flg(8'h00);
    rdc(OFF_FLAGS, 32'h0, "flags_sync");
    sgap(g);
    chk("sample_gap", 32'h1, {31'h0, (g >= 480 && g <= 520)});
    apb(1'b1, OFF_CYCLE, 32'h64);
    @(posedge pclk);
    #1;
    flg(8'h04);
    // 55 us cannot lock to 10 us
    apb(1'b1, OFF_CYCLE, 32'h37);
    tk(155);
    flg(8'h04);
    // 50 us converter cycle dividing a 100 us link cycle, realigned each tick
    period <= 16'h03E8;
    apb(1'b1, OFF_CYCLE, 32'h32);
    tk(4);
    sgap(g);
    chk("div_sample_gap", 32'h1, {31'h0, (g >= 480 && g <= 520)});
    rdc(OFF_LINK, 32'h64, "link_us_div");
    complete_run();
  end
endmodule
`default_nettype wire
